/* File: common/uie_pkg.sv */
// Package for the USB interrupt enable and control register slice
package uie_pkg;

    // Register byte offsets
    localparam logic [7:0] UIE_OFS_IRQ_EN = 8'h00;
    localparam logic [7:0] UIE_OFS_CTRL = 8'h04;
    localparam logic [7:0] UIE_OFS_EVT_STAT = 8'h08;
    localparam logic [7:0] UIE_OFS_EVT_MASK = 8'h0C;

    // Field positions, shared by enable, event status and event mask layouts
    localparam int UIE_BIT_STALL = 7;
    localparam int UIE_BIT_ATTACH = 6;
    localparam int UIE_BIT_RESUME = 5;
    localparam int UIE_BIT_IDLE = 4;
    localparam int UIE_BIT_TOKEN_DONE = 3;
    localparam int UIE_BIT_FRAME_START = 2;
    localparam int UIE_BIT_ERROR = 1;
    localparam int UIE_BIT_RESET_DETACH = 0;

    // Control register fields
    localparam int UIE_CTL_J = 7;
    localparam int UIE_CTL_SE0 = 6;
    localparam int UIE_CTL_PACKET_DISABLE = 5;
    localparam int UIE_CTL_BUSRST = 4;
    localparam int UIE_CTL_HOST_MODE_ENABLE = 3;
    localparam int UIE_CTL_RESUME = 2;
    localparam int UIE_CTL_PPRST = 1;
    localparam int UIE_CTL_ENABLE = 0;

    // Reset values
    localparam logic [7:0] UIE_RST_IRQ_EN = 8'h00;
    localparam logic [7:0] UIE_RST_CTRL = 8'h00;
    localparam logic [7:0] UIE_RST_EVT = 8'h00;

    // Cycles of the host control logic reset pulse after a host enable change
    localparam logic [1:0] UIE_HOST_RST_CYCLES = 2'h2;

    // Line state sampled from the transceiver
    typedef struct packed {
        logic j_state;
        logic se0;
    } uie_line_t;

    // Event pulses from the protocol engine
    typedef struct packed {
        logic stall;
        logic attach;
        logic resume;
        logic idle;
        logic token_done;
        logic frame_start;
        logic error;
        logic reset_detach;
        logic setup_rx;
        logic token_busy;
    } uie_evt_t;

    // Control outputs to the protocol engine
    typedef struct packed {
        logic packet_disable;
        logic bus_reset_drive;
        logic host_mode_enable;
        logic resume_drive;
        logic pingpong_reset;
        logic module_enable;
        logic host_logic_reset;
        logic ls_eop_append;
    } uie_ctl_t;

    typedef enum logic [1:0] {
        UIE_APB_IDLE,
        UIE_APB_ACCESS
    } uie_apb_t;

endpackage : uie_pkg

/* File: dv/testbench.sv */
// Self-checking testbench for the USB interrupt enable and control slice
`timescale 1ns/1ps

module testbench
    import uie_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic clear = 1'b0;
    logic setup = 1'b0;
    logic serr;
    logic pready;
    logic pslverr;
    logic summary_irq_flag;
    logic irq;
    logic [7:0] paddr = 8'h00;
    logic [7:0] raise = 8'h00;
    logic [7:0] b;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdv;
    uie_line_t line_set = '0;
    uie_line_t line;
    uie_evt_t evt;
    uie_ctl_t ctl;
    int errors = 0;
    int n_checks = 0;
    int n_hrst = 0;
    int n_eop = 0;

    //////////////////////////////////////////////////////////////////////////
    // Clock, slice and far-side model
    always #4 pclk = ~pclk;

    uie_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line(line), .evt(evt), .ctl(ctl), .summary_irq_flag(summary_irq_flag), .irq(irq));

    uie_usb_model usb (.pclk(pclk), .presetn(presetn), .raise(raise), .clear(clear), .setup(setup),
        .line_set(line_set), .ctl(ctl), .evt(evt), .line(line));

    // Count host reset cycles and EOP pulses as they pass
    always @(posedge pclk)
    begin
        if (ctl.host_logic_reset === 1'b1) n_hrst++;
        if (ctl.ls_eop_append === 1'b1) n_eop++;
    end

    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; a free edge first keeps psel from being set twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for ready however long it takes; only the watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rdv, exp);
    endtask : rdc

    task automatic pulse(input logic [7:0] m, input logic c, input logic s);
        @(posedge pclk);
        raise <= m;
        clear <= c;
        setup <= s;
        @(posedge pclk);
        raise <= 8'h00;
        clear <= 1'b0;
        setup <= 1'b0;
    endtask : pulse

    // Wait whole cycles, then look where outputs have settled
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : wt

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc("irq_en reset", UIE_OFS_IRQ_EN, 32'h0);
        rdc("ctrl reset", UIE_OFS_CTRL, 32'h0);
        apb(1'b1, UIE_OFS_IRQ_EN, 32'hFFFFFFFF);
        rdc("irq_en upper", UIE_OFS_IRQ_EN, 32'hFF);
        apb(1'b1, UIE_OFS_CTRL, 32'hFFFFFF00);
        rdc("ctrl upper", UIE_OFS_CTRL, 32'h0);
        $display("Test widths done");
        // Every source, first blocked by its own enable, then passed
        for (int i = 0; i < 8; i++)
        begin
            b = 8'h01 << i;
            apb(1'b1, UIE_OFS_EVT_MASK, {24'h0, {8{i[0]}}});
            apb(1'b1, UIE_OFS_IRQ_EN, {24'h0, ~b});
            pulse(b, 1'b0, 1'b0);
            wt(2);
            chk("summary blocked", summary_irq_flag, 1'b0);
            chk("irq masked", irq, i[0]);
            apb(1'b1, UIE_OFS_IRQ_EN, {24'h0, b});
            wt(2);
            chk("summary passed", summary_irq_flag, 1'b1);
            pulse(8'h00, 1'b1, 1'b0);
            rdc("status", UIE_OFS_EVT_STAT, {24'h0, b});
            wt(1);
            chk("irq cleared", irq, 1'b0);
        end
        $display("Test enables done");
        // Host mode; resume held only briefly, the hold time is software's
        line_set <= '{j_state: 1'b1, se0: 1'b0};
        apb(1'b1, UIE_OFS_CTRL, 32'h09);
        wt(5);
        chk("host reset on", n_hrst, 2);
        rdc("ctrl host", UIE_OFS_CTRL, 32'h89);
        apb(1'b1, UIE_OFS_IRQ_EN, 32'h01);
        pulse(8'h01, 1'b0, 1'b0);
        wt(2);
        chk("detach", summary_irq_flag, 1'b1);
        pulse(8'h00, 1'b1, 1'b1);
        wt(2);
        chk("host setup", ctl.packet_disable, 1'b0);
        apb(1'b1, UIE_OFS_CTRL, 32'h0D);
        wt(0);
        chk("resume drive", ctl.resume_drive, 1'b1);
        apb(1'b1, UIE_OFS_CTRL, 32'h09);
        wt(3);
        chk("eop host", n_eop, 1);
        apb(1'b1, UIE_OFS_CTRL, 32'h01);
        wt(5);
        chk("host reset off", n_hrst, 4);
        apb(1'b1, UIE_OFS_CTRL, 32'h05);
        apb(1'b1, UIE_OFS_CTRL, 32'h01);
        wt(3);
        chk("eop device", n_eop, 1);
        pulse(8'h00, 1'b0, 1'b1);
        wt(2);
        chk("pkt disable", ctl.packet_disable, 1'b1);
        rdc("ctrl pkt", UIE_OFS_CTRL, 32'hA1);
        apb(1'b1, UIE_OFS_CTRL, 32'h11);
        rdc("ctrl se0", UIE_OFS_CTRL, 32'h51);
        apb(1'b1, 8'h10, 32'hFF);
        chk("slverr", serr, 1'b1);
        rdc("unmapped", 8'h10, 32'h0);
        $display("Test control done");
        report_and_stop();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end
endmodule : testbench

/* File: dv/uie_usb_model.sv */
// Behavioural model of the USB engine and transceiver beside the register slice
`timescale 1ns/1ps

module uie_usb_model
    import uie_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic [7:0] raise, // Flags to raise
    input wire logic clear, // Drop all raised flags
    input wire logic setup, // SETUP token seen
    input wire uie_pkg::uie_line_t line_set, // Line level from the far end
    input wire uie_pkg::uie_ctl_t ctl, // Control from the slice
    output uie_pkg::uie_evt_t evt, // Events to the slice
    output uie_pkg::uie_line_t line // Line state to the slice
);
    //////////////////////////////////////////////////////////////////////////
    // Flags stay up until cleared, as the engine's own flag bits do
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt <= '0;
        else
        begin
            evt[9:2] <= clear ? 8'h00 : (evt[9:2] | raise);
            evt.setup_rx <= setup;
            evt.token_busy <= 1'b0;
        end
    end

    // Driving bus reset puts SE0 on the wire whatever the far end does
    assign line = ctl.bus_reset_drive ? 2'h1 : line_set;
endmodule : uie_usb_model

/* File: verilog/uie_regs.sv */
// USB interrupt enable and control registers behind an APB slave
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module uie_regs
(
    input wire logic pclk, // Clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire uie_pkg::uie_line_t line, // Live line state
    input wire uie_pkg::uie_evt_t evt, // Engine events
    output uie_pkg::uie_ctl_t ctl, // Control to engine
    output logic summary_irq_flag, // Summary interrupt level
    output logic irq // Masked event status interrupt
);
    import uie_pkg::*;

    logic [7:0] irq_en;
    logic [7:0] ctrl_q;
    logic [7:0] evt_stat;
    logic [7:0] evt_mask;
    logic [7:0] raw_flags;
    logic [7:0] next_evt_stat;
    logic [1:0] host_rst_cnt;
    logic wr_en;
    logic rd_en;
    logic wr_ctrl;
    logic host_flip;
    logic resume_fall;
    logic [7:0] ctrl_wdata;
    logic eop_q;

    // Address decode used by both read and write paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == UIE_OFS_IRQ_EN) || (a == UIE_OFS_CTRL) ||
                  (a == UIE_OFS_EVT_STAT) || (a == UIE_OFS_EVT_MASK);
    endfunction : addr_ok

    //////////////////////////////////////////////////////////////////////////
    // APB handshake: zero wait states, so ready is tied to the access phase
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~addr_ok(paddr);
    assign wr_en = psel & penable & pwrite & addr_ok(paddr);
    assign rd_en = psel & penable & ~pwrite & addr_ok(paddr);
    assign wr_ctrl = wr_en && (paddr == UIE_OFS_CTRL);
    assign ctrl_wdata = pwdata[7:0];

    //////////////////////////////////////////////////////////////////////////
    // Interrupt enable register; upper write bits simply dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en <= UIE_RST_IRQ_EN;
        else if (wr_en && paddr == UIE_OFS_IRQ_EN)
            irq_en <= pwdata[7:0];
    end

    // Control register, writable bits only; line flags are never stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= UIE_RST_CTRL;
        else
        begin
            ctrl_q[UIE_CTL_J] <= 1'b0;
            ctrl_q[UIE_CTL_SE0] <= 1'b0;
            if (wr_ctrl)
                ctrl_q[5:0] <= ctrl_wdata[5:0];
            // Setup in device mode wins over a same-cycle software clear
            if (evt.setup_rx && !ctrl_q[UIE_CTL_HOST_MODE_ENABLE])
                ctrl_q[UIE_CTL_PACKET_DISABLE] <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Host logic reset on any change of host enable, in either direction
    assign host_flip = wr_ctrl && (ctrl_wdata[UIE_CTL_HOST_MODE_ENABLE] != ctrl_q[UIE_CTL_HOST_MODE_ENABLE]);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            host_rst_cnt <= 2'h0;
        else if (host_flip)
            host_rst_cnt <= UIE_HOST_RST_CYCLES;
        else if (host_rst_cnt != 2'h0)
            host_rst_cnt <= host_rst_cnt - 2'h1;
    end

    // Resume falling edge in host mode asks the engine for a low speed EOP
    assign resume_fall = wr_ctrl && ctrl_q[UIE_CTL_RESUME] && !ctrl_wdata[UIE_CTL_RESUME];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            eop_q <= 1'b0;
        else
            eop_q <= resume_fall && ctrl_q[UIE_CTL_HOST_MODE_ENABLE];
    end

    // Control outputs straight from the stored bits, host reset decoded from its counter; the whole word is built
    // in one assignment so the struct never has a clocked and an assigned driver
    assign ctl = '{
        packet_disable: ctrl_q[UIE_CTL_PACKET_DISABLE],
        bus_reset_drive: ctrl_q[UIE_CTL_BUSRST],
        host_mode_enable: ctrl_q[UIE_CTL_HOST_MODE_ENABLE],
        resume_drive: ctrl_q[UIE_CTL_RESUME],
        pingpong_reset: ctrl_q[UIE_CTL_PPRST],
        module_enable: ctrl_q[UIE_CTL_ENABLE],
        host_logic_reset: (host_rst_cnt != 2'h0),
        ls_eop_append: eop_q
    };

    //////////////////////////////////////////////////////////////////////////
    // Summary flag: each raised flag gated by its enable, then ORed
    // Bit 0 means bus reset in device mode and detach in host mode; the engine
    // reports whichever applies on the same wire, so the gating is identical.
    assign raw_flags = {evt.stall, evt.attach, evt.resume, evt.idle,
                        evt.token_done, evt.frame_start, evt.error, evt.reset_detach};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            summary_irq_flag <= 1'b0;
        else
            summary_irq_flag <= |(raw_flags & irq_en);
    end

    //////////////////////////////////////////////////////////////////////////
    // Sticky event status, cleared by reading it; a new event wins the clear
    always_comb
    begin
        next_evt_stat = evt_stat;
        if (rd_en && paddr == UIE_OFS_EVT_STAT)
            next_evt_stat = 8'h00;
        next_evt_stat = next_evt_stat | raw_flags;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_stat <= UIE_RST_EVT;
        else
            evt_stat <= next_evt_stat;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_mask <= UIE_RST_EVT;
        else if (wr_en && paddr == UIE_OFS_EVT_MASK)
            evt_mask <= pwdata[7:0];
    end

    assign irq = |(evt_stat & evt_mask);

    //////////////////////////////////////////////////////////////////////////
    // Read data registered in the setup phase so it is valid in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                UIE_OFS_IRQ_EN: prdata <= {24'h00_0000, irq_en};
                UIE_OFS_CTRL: prdata <= {24'h00_0000, line.j_state, line.se0,
                                        ctrl_q[5], ctrl_q[4], ctrl_q[3], ctrl_q[2], ctrl_q[1], ctrl_q[0]};
                UIE_OFS_EVT_STAT: prdata <= {24'h00_0000, evt_stat};
                UIE_OFS_EVT_MASK: prdata <= {24'h00_0000, evt_mask};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == UIE_OFS_IRQ_EN) |=> prdata[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("enable upper bits not zero");

    property p_en_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == UIE_OFS_IRQ_EN) |=> irq_en == $past(pwdata[7:0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_err_gate;
        @(posedge pclk) disable iff (!presetn)
        (evt.error && irq_en[UIE_BIT_ERROR]) |=> summary_irq_flag;
    endproperty
    a_err_gate: assert property (p_err_gate) else $error("error not forwarded");

    property p_masked_quiet;
        @(posedge pclk) disable iff (!presetn)
        ((raw_flags & irq_en) == 8'h00) |=> !summary_irq_flag;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked flag interrupted");

    property p_stall_gate;
        @(posedge pclk) disable iff (!presetn)
        (evt.stall && irq_en[UIE_BIT_STALL]) |=> summary_irq_flag;
    endproperty
    a_stall_gate: assert property (p_stall_gate) else $error("stall not forwarded");

    property p_reset_gate;
        @(posedge pclk) disable iff (!presetn)
        (evt.reset_detach && irq_en[UIE_BIT_RESET_DETACH]) |=> summary_irq_flag;
    endproperty
    a_reset_gate: assert property (p_reset_gate) else $error("bit 0 flag not forwarded");

    property p_setup_packet_disable;
        @(posedge pclk) disable iff (!presetn)
        (evt.setup_rx && !ctl.host_mode_enable) |=> ctl.packet_disable;
    endproperty
    a_setup_packet_disable: assert property (p_setup_packet_disable) else $error("setup did not disable");

    property p_host_reset;
        @(posedge pclk) disable iff (!presetn)
        host_flip |=> ctl.host_logic_reset [*2] ##1 !ctl.host_logic_reset || $past(host_flip, 1);
    endproperty
    a_host_reset: assert property (p_host_reset) else $error("host reset pulse wrong");

    property p_line_live;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == UIE_OFS_CTRL) |=> prdata[7:6] == $past({line.j_state, line.se0});
    endproperty
    a_line_live: assert property (p_line_live) else $error("line state not live");

    property p_eop;
        @(posedge pclk) disable iff (!presetn)
        (resume_fall && ctl.host_mode_enable) |=> ctl.ls_eop_append;
    endproperty
    a_eop: assert property (p_eop) else $error("no low speed eop");

    property p_ctl_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == UIE_OFS_CTRL) |=> prdata[31:8] == 24'h00_0000;
    endproperty
    a_ctl_upper_zero: assert property (p_ctl_upper_zero) else $error("control upper bits not zero");

    property p_packet_disable_hold;
        @(posedge pclk) disable iff (!presetn)
        (ctl.packet_disable && !wr_ctrl) |=> ctl.packet_disable;
    endproperty
    a_packet_disable_hold: assert property (p_packet_disable_hold) else $error("packet disable dropped by itself");

    property p_eop_device;
        @(posedge pclk) disable iff (!presetn)
        (resume_fall && !ctl.host_mode_enable) |=> !ctl.ls_eop_append;
    endproperty
    a_eop_device: assert property (p_eop_device) else $error("eop appended in device mode");

    property p_host_quiet;
        @(posedge pclk) disable iff (!presetn)
        (!host_flip && !ctl.host_logic_reset) |=> !ctl.host_logic_reset;
    endproperty
    a_host_quiet: assert property (p_host_quiet) else $error("host reset without a change");

    property p_idle_gate;
        @(posedge pclk) disable iff (!presetn)
        (evt.idle && irq_en[UIE_BIT_IDLE]) |=> summary_irq_flag;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("idle not forwarded");

    property p_attach_gate;
        @(posedge pclk) disable iff (!presetn)
        (evt.attach && irq_en[UIE_BIT_ATTACH]) |=> summary_irq_flag;
    endproperty
    a_attach_gate: assert property (p_attach_gate) else $error("attach not forwarded");

    property p_token_gate;
        @(posedge pclk) disable iff (!presetn)
        (evt.token_done && irq_en[UIE_BIT_TOKEN_DONE]) |=> summary_irq_flag;
    endproperty
    a_token_gate: assert property (p_token_gate) else $error("token done not forwarded");

    c_err_irq: cover property (@(posedge pclk) disable iff (!presetn) evt.error ##1 summary_irq_flag);
    c_setup: cover property (@(posedge pclk) disable iff (!presetn) evt.setup_rx ##1 ctl.packet_disable);
    c_host_flip: cover property (@(posedge pclk) disable iff (!presetn) host_flip);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
    c_eop: cover property (@(posedge pclk) disable iff (!presetn) ctl.ls_eop_append);

endmodule : uie_regs
